// file: rtl/sdp_pkg.sv
package sdp_pkg;
    // buffer geometry
    localparam int SDP_IDX_W = 10;
    localparam int SDP_FILL_W = 11;
    localparam logic [10:0] SDP_FILL_FULL = 11'h400;
    // timing base
    localparam int SDP_CLK_NS = 4;
    localparam int SDP_MS_NS = 1000000;
    localparam int SDP_MS_CYCLES = (SDP_MS_NS + SDP_CLK_NS - 1) / SDP_CLK_NS;
    localparam int SDP_DIV_W = 18;
    // register word indices
    localparam logic [5:0] SDP_REG_LEN = 6'h00;
    localparam logic [5:0] SDP_REG_DELIM = 6'h01;
    localparam logic [5:0] SDP_REG_FORCE = 6'h02;
    localparam logic [5:0] SDP_REG_DBEG = 6'h03;
    localparam logic [5:0] SDP_REG_DEND = 6'h04;
    localparam logic [5:0] SDP_REG_STAT = 6'h05;
    // delimiter register fields
    localparam int SDP_D1_LSB = 0;
    localparam int SDP_D2_LSB = 8;
    localparam int SDP_MATCH2_BIT = 16;
    localparam int SDP_PROC_LSB = 17;
    localparam logic [31:0] SDP_DELIM_RST = 32'h0001_0000;
    // destination handling
    localparam logic [7:0] SDP_HOST_BCAST = 8'hff;
    localparam logic [7:0] SDP_RANGE_MAX = 8'h3f;
    // tail byte options
    typedef enum logic [1:0] {
        SDP_PROC_NONE = 2'b00,
        SDP_PROC_PLUS1 = 2'b01,
        SDP_PROC_PLUS2 = 2'b10
    } sdp_proc_type;
    typedef enum logic [1:0] {
        SDP_ST_COLLECT = 2'b00,
        SDP_ST_FETCH = 2'b01,
        SDP_ST_SHOW = 2'b10,
        SDP_ST_ADVANCE = 2'b11
    } sdp_state_type;
    // one outgoing byte with its frame context
    typedef struct packed {
        logic [7:0] data;
        logic last;
        logic bcast;
        logic [31:0] dest;
    } sdp_tx_type;
endpackage : sdp_pkg

// file: rtl/sdp_byte_ram.sv
`timescale 1ns/10ps
`default_nettype none
module sdp_byte_ram #(
    parameter int DW = 8,
    parameter int AW = 10
) (
    input wire logic mclk, // system clock
    input wire logic rst_n, // async reset, low
    input wire logic we, // write strobe
    input wire logic [AW-1:0] waddr, // write index
    input wire logic [DW-1:0] wdata, // write byte
    input wire logic re, // read strobe
    input wire logic [AW-1:0] raddr, // read index
    output logic [DW-1:0] rdata // registered read byte
);
    logic [DW-1:0] mem [2**AW];

    // storage write, no reset on the array
    always_ff @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // registered read, holds between strobes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule : sdp_byte_ram
`default_nettype wire

// file: rtl/sdp_dest_walk.sv
`timescale 1ns/10ps
`default_nettype none
module sdp_dest_walk
    import sdp_pkg::*;
(
    input wire logic mclk, // system clock
    input wire logic rst_n, // async reset, low
    input wire logic load, // latch a new range
    input wire logic step, // move to next address
    input wire logic [31:0] dbeg, // begin address
    input wire logic [31:0] dend, // end address
    output logic [31:0] addr, // current destination
    output logic last, // current is final one
    output logic bcast // subnet broadcast
);
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] endp;
        logic bcast;
    } sdp_walk_type;
    sdp_walk_type s, next_s;
    logic [7:0] span;
    logic ok;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // range check and stepping
    always_comb begin
        next_s = s;
        span = dend[7:0] - dbeg[7:0];
        ok = (dend[31:8] == dbeg[31:8]) && (dend[7:0] >= dbeg[7:0]) && (span <= SDP_RANGE_MAX);
        if (load) begin
            next_s.addr = dbeg;
            // R17 broadcast host
            next_s.bcast = (dbeg[7:0] == SDP_HOST_BCAST);
            // R16 range limit
            next_s.endp = (ok && !next_s.bcast) ? dend : dbeg;
        end else if (step && !last) begin
            next_s.addr[7:0] = s.addr[7:0] + 8'h01;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign addr = s.addr;
    assign last = (s.addr == s.endp);
    assign bcast = s.bcast;

    chk_range_span: assert property ((s.addr[31:8] == s.endp[31:8]) && (8'(s.endp[7:0] - s.addr[7:0]) <= SDP_RANGE_MAX)) // R16
        else $error("destination range too wide");
    chk_bcast_single: assert property (load && dbeg[7:0] == SDP_HOST_BCAST |=> s.bcast && last) // R17
        else $error("broadcast not a single send");
endmodule : sdp_dest_walk
`default_nettype wire

// file: rtl/sdp_packer.sv
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// R01: packet length zero means no length limit on a frame.
// R02: length 1 to 1024 closes the frame when that many bytes are held.
// R03: with no delimiters every received byte is sent on its own.
// R04: with delimiters bytes accumulate until the delimiter condition, then are sent.
// R05: two 8-bit delimiter characters, zero meaning unused; both zero disables.
// R06: a full 1K buffer is sent and emptied.
// R07: one-byte match: either delimiter alone closes the frame.
// R08: two-byte match: first delimiter followed by second closes the frame.
// R09: tail option needs delimiter one; with both, it starts after the pair.
// R10: no-extra option sends at the delimiter itself.
// R11: plus-one option takes one more byte, then sends.
// R12: plus-two option takes two more bytes, then sends.
// R13: idle timeout zero disables flushing on inactivity.
// R14: idle timeout 1 to 65535 ms flushes held bytes after that gap.
// R15: software should pick a timeout longer than one character time.
// R16: destination range up to 64 addresses; each frame goes to each.
// R17: begin host 255 sends each frame as subnet broadcast.
// R18: idle timer restarts per byte, clears on flush, counts ms ticks.
module sdp_packer
    import sdp_pkg::*;
#(
    parameter int MS_CYCLES = SDP_MS_CYCLES
) (
    input wire logic mclk, // system clock
    input wire logic rst_n, // async reset, low
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // bus strobe
    input wire logic wb_we_i, // bus write
    input wire logic [7:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // bus acknowledge
    input wire logic rx_valid, // serial byte present
    input wire logic [7:0] rx_data, // serial byte
    output logic rx_ready, // byte may be taken
    output logic tx_valid, // network byte present
    output sdp_tx_type tx_frm, // network byte and context
    input wire logic tx_ready // network side takes byte
);
    typedef struct packed {
        logic [SDP_FILL_W-1:0] len;
        logic [31:0] delim;
        logic [15:0] force_ms;
        logic [31:0] dbeg;
        logic [31:0] dend;
        logic ack;
        logic [31:0] rdat;
        sdp_state_type st;
        logic [SDP_FILL_W-1:0] fill;
        logic [SDP_IDX_W-1:0] rd_idx;
        logic [1:0] tail;
        logic tail_on;
        logic prev_d1;
        logic [SDP_DIV_W-1:0] div;
        logic [15:0] idle;
        logic [15:0] frames;
        logic rx_rdy;
        logic tx_valid;
        sdp_tx_type tx;
    } sdp_core_type;

    sdp_core_type s, next_s;
    logic [7:0] d1;
    logic [7:0] d2;
    logic d1_en;
    logic d2_en;
    logic two_mode;
    logic [1:0] extra;
    logic hit1;
    logic hit2;
    logic met;
    logic acc;
    logic [SDP_FILL_W-1:0] fill_new;
    logic len_hit;
    logic full_hit;
    logic tmo_hit;
    logic close;
    logic dload;
    logic dstep;
    logic [7:0] ram_q;
    logic [31:0] dest_addr;
    logic dest_last;
    logic dest_bcast;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // byte-lane merge of a register write
    function automatic logic [31:0] sdp_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : sdp_merge

    // R05 delimiter characters, zero unused
    assign d1 = s.delim[SDP_D1_LSB +: 8];
    assign d2 = s.delim[SDP_D2_LSB +: 8];
    assign d1_en = (d1 != 8'h00);
    assign d2_en = (d2 != 8'h00);
    assign two_mode = s.delim[SDP_MATCH2_BIT] && d1_en && d2_en;
    assign hit1 = d1_en && (rx_data == d1);
    assign hit2 = d2_en && (rx_data == d2);

    // R09 tail option only with delimiter one
    always_comb begin
        extra = 2'h0;
        if (d1_en && s.delim[SDP_PROC_LSB +: 2] == SDP_PROC_PLUS1) begin
            extra = 2'h1;
        end else if (d1_en && s.delim[SDP_PROC_LSB +: 2] == SDP_PROC_PLUS2) begin
            extra = 2'h2;
        end
    end

    // R07 R08 delimiter condition
    assign met = two_mode ? (s.prev_d1 && hit2) : (hit1 || hit2);

    // accept and closing terms
    assign acc = (s.st == SDP_ST_COLLECT) && s.rx_rdy && rx_valid;
    assign fill_new = s.fill + 11'h001;
    // R01 R02 length limit only when nonzero
    assign len_hit = (s.len != '0) && (fill_new == s.len);
    // R06 full buffer
    assign full_hit = (fill_new == SDP_FILL_FULL);
    // R13 R14 idle gap in ms
    assign tmo_hit = (s.force_ms != 16'h0000) && (s.fill != '0) && (s.idle >= s.force_ms);

    // next-state logic
    always_comb begin
        next_s = s;
        close = 1'b0;
        dload = 1'b0;
        dstep = 1'b0;
        next_s.ack = 1'b0;
        // bus slave, one wait cycle, unmapped reads zero
        if (wb_cyc_i && wb_stb_i && !s.ack) begin
            next_s.ack = 1'b1;
            next_s.rdat = 32'h0000_0000;
            case (wb_adr_i[7:2])
                SDP_REG_LEN: begin
                    next_s.rdat = 32'(s.len);
                    if (wb_we_i) begin
                        next_s.len = SDP_FILL_W'(sdp_merge(32'(s.len), wb_dat_i, wb_sel_i));
                    end
                end
                SDP_REG_DELIM: begin
                    next_s.rdat = s.delim;
                    if (wb_we_i) begin
                        next_s.delim = sdp_merge(s.delim, wb_dat_i, wb_sel_i);
                    end
                end
                SDP_REG_FORCE: begin
                    next_s.rdat = 32'(s.force_ms);
                    if (wb_we_i) begin
                        next_s.force_ms = 16'(sdp_merge(32'(s.force_ms), wb_dat_i, wb_sel_i));
                    end
                end
                SDP_REG_DBEG: begin
                    next_s.rdat = s.dbeg;
                    if (wb_we_i) begin
                        next_s.dbeg = sdp_merge(s.dbeg, wb_dat_i, wb_sel_i);
                    end
                end
                SDP_REG_DEND: begin
                    next_s.rdat = s.dend;
                    if (wb_we_i) begin
                        next_s.dend = sdp_merge(s.dend, wb_dat_i, wb_sel_i);
                    end
                end
                SDP_REG_STAT: begin
                    next_s.rdat = {s.frames, 3'h0, s.st, s.fill};
                end
                default: begin
                    next_s.rdat = 32'h0000_0000;
                end
            endcase
        end
        // packing sequence
        unique case (s.st)
            SDP_ST_COLLECT: begin
                if (acc) begin
                    next_s.fill = fill_new;
                    // R18 restart idle timer per byte
                    next_s.div = '0;
                    next_s.idle = '0;
                    next_s.prev_d1 = hit1;
                    if (s.tail_on) begin
                        // R11 R12 counting tail bytes
                        next_s.tail = s.tail - 2'h1;
                        close = (s.tail == 2'h1);
                    end else if (met) begin
                        // R04 R10 send at delimiter or arm tail
                        if (extra == 2'h0) begin
                            close = 1'b1;
                        end else begin
                            next_s.tail_on = 1'b1;
                            next_s.tail = extra;
                        end
                    end
                    // R03 no delimiters, byte goes at once
                    if (!d1_en && !d2_en) begin
                        close = 1'b1;
                    end
                    // R02 R06 length and full limits
                    if (len_hit || full_hit) begin
                        close = 1'b1;
                    end
                end else if (s.fill != '0) begin
                    // R18 ms tick from divider
                    if (s.div == SDP_DIV_W'(MS_CYCLES - 1)) begin
                        next_s.div = '0;
                        if (s.idle != 16'hffff) begin
                            next_s.idle = s.idle + 16'h0001;
                        end
                    end else begin
                        next_s.div = s.div + 1'b1;
                    end
                    // R14 flush on idle gap
                    close = tmo_hit;
                end
                if (close) begin
                    next_s.st = SDP_ST_FETCH;
                    next_s.rd_idx = '0;
                    next_s.tail_on = 1'b0;
                    next_s.tail = 2'h0;
                    next_s.prev_d1 = 1'b0;
                    // R18 clear timer on flush
                    next_s.div = '0;
                    next_s.idle = '0;
                    dload = 1'b1;
                end
            end
            SDP_ST_FETCH: begin
                next_s.st = SDP_ST_SHOW;
            end
            SDP_ST_SHOW: begin
                if (!s.tx_valid) begin
                    next_s.tx_valid = 1'b1;
                    next_s.tx.data = ram_q;
                    next_s.tx.last = (({1'b0, s.rd_idx} + 11'h001) == s.fill);
                    next_s.tx.dest = dest_addr;
                    next_s.tx.bcast = dest_bcast;
                end else if (tx_ready) begin
                    next_s.tx_valid = 1'b0;
                    if (s.tx.last) begin
                        next_s.st = SDP_ST_ADVANCE;
                    end else begin
                        next_s.rd_idx = s.rd_idx + 1'b1;
                        next_s.st = SDP_ST_FETCH;
                    end
                end
            end
            SDP_ST_ADVANCE: begin
                // R16 replay frame for each address
                if (dest_last) begin
                    next_s.fill = '0;
                    next_s.frames = s.frames + 16'h0001;
                    next_s.st = SDP_ST_COLLECT;
                end else begin
                    dstep = 1'b1;
                    next_s.rd_idx = '0;
                    next_s.st = SDP_ST_FETCH;
                end
            end
        endcase
        // source stalls while a frame drains
        next_s.rx_rdy = (next_s.st == SDP_ST_COLLECT);
    end

    // state register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.delim <= SDP_DELIM_RST;
        end else begin
            s <= next_s;
        end
    end

    // frame buffer
    sdp_byte_ram #(
        .DW(8),
        .AW(SDP_IDX_W)
    ) u_ram (
        .mclk(mclk),
        .rst_n(rst_n),
        .we(acc),
        .waddr(s.fill[SDP_IDX_W-1:0]),
        .wdata(rx_data),
        .re(s.st == SDP_ST_FETCH),
        .raddr(s.rd_idx),
        .rdata(ram_q)
    );

    // destination sequencer
    sdp_dest_walk u_dest (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(dload),
        .step(dstep),
        .dbeg(s.dbeg),
        .dend(s.dend),
        .addr(dest_addr),
        .last(dest_last),
        .bcast(dest_bcast)
    );

    // outputs from flops
    assign wb_dat_o = s.rdat;
    assign wb_ack_o = s.ack;
    assign rx_ready = s.rx_rdy;
    assign tx_valid = s.tx_valid;
    assign tx_frm = s.tx;

    chk_len_free: assert property (acc && s.len == '0 && (d1_en || d2_en) && !met && !s.tail_on && !full_hit |=> s.st == SDP_ST_COLLECT) // R01
        else $error("frame closed without cause");
    chk_len_close: assert property (acc && len_hit |-> ##3 s.tx_valid) // R02
        else $error("length limit did not send");
    chk_byte_pass: assert property (acc && !d1_en && !d2_en && s.fill == '0 |-> ##3 (s.tx_valid && s.tx.last)) // R03
        else $error("byte not sent alone");
    chk_delim_send: assert property (acc && met && !s.tail_on && extra == 2'h0 |-> ##3 s.tx_valid) // R04
        else $error("delimiter did not send");
    chk_full_close: assert property (acc && s.fill == SDP_FILL_FULL - 11'h001 |=> s.st == SDP_ST_FETCH ##1 s.st == SDP_ST_SHOW) // R06
        else $error("full buffer not flushed");
    chk_one_match: assert property (acc && !two_mode && (hit1 || hit2) && !s.tail_on && extra == 2'h0 |=> s.st == SDP_ST_FETCH) // R07
        else $error("single delimiter missed");
    chk_pair_match: assert property (acc && two_mode && !s.prev_d1 && !s.tail_on && !len_hit && !full_hit |=> s.st == SDP_ST_COLLECT) // R08
        else $error("pair matched out of order");
    chk_proc_gate: assert property (acc && met && !d1_en && !s.tail_on |=> s.st == SDP_ST_FETCH && !s.tail_on) // R09
        else $error("tail armed without delimiter one");
    chk_tail_one: assert property (acc && s.tail_on && s.tail == 2'h1 |=> s.st == SDP_ST_FETCH && s.fill == $past(fill_new)) // R11
        else $error("tail byte not closing");
    chk_tail_two: assert property (acc && s.tail_on && s.tail == 2'h2 && !len_hit && !full_hit |=> s.st == SDP_ST_COLLECT && s.tail_on) // R12
        else $error("second tail byte lost");
    chk_tmo_off: assert property (s.st == SDP_ST_COLLECT && !acc && s.force_ms == 16'h0000 |=> s.st == SDP_ST_COLLECT) // R13
        else $error("flush with timeout disabled");
    chk_tmo_close: assert property (s.st == SDP_ST_COLLECT && !acc && tmo_hit |=> s.st == SDP_ST_FETCH && s.idle == 16'h0000) // R14
        else $error("idle gap not flushed");
    chk_idle_restart: assert property (acc |=> s.idle == 16'h0000 && s.div == '0) // R18
        else $error("idle timer not restarted");
endmodule : sdp_packer
`default_nettype wire

// file: verification/sdp_far_end.sv
`timescale 1ns/10ps
`default_nettype none
// serial byte source and network sink
module sdp_far_end
    import sdp_pkg::*;
(
    input wire logic mclk, // system clock
    input wire logic rst_n, // async reset, low
    input wire logic push, // queue one byte
    input wire logic [7:0] push_byte, // byte to queue
    input wire logic stall, // slow network side
    output var logic rx_valid, // serial byte present
    output var logic [7:0] rx_data, // serial byte
    input wire logic rx_ready, // packer takes byte
    input wire logic tx_valid, // network byte present
    input wire sdp_tx_type tx_frm, // network byte
    output var logic tx_ready, // sink accepts
    output var logic got, // byte accepted
    output var sdp_tx_type got_frm // accepted byte
);
    logic [7:0] q[$];
    // source holds each byte until taken; sink toggles ready when stalled
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q.delete();
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
            tx_ready <= 1'b0;
            got <= 1'b0;
            got_frm <= '0;
        end else begin
            got <= tx_valid && tx_ready;
            got_frm <= tx_frm;
            tx_ready <= stall ? ~tx_ready : 1'b1;
            if (rx_valid && rx_ready) begin
                void'(q.pop_front());
            end
            if (push) begin
                q.push_back(push_byte);
            end
            // idle data line shows the inverse of its last value
            if (q.size() > 0) begin
                rx_valid <= 1'b1;
                rx_data <= q[0];
            end else begin
                rx_valid <= 1'b0;
                rx_data <= ~rx_data;
            end
        end
    end
endmodule : sdp_far_end
`default_nettype wire

// file: verification/sdp_packer_test.sv
`timescale 1ns/10ps
`default_nettype none
module sdp_packer_test
    import sdp_pkg::*;
;
    logic mclk, rst_n, cyc, stb, we, ack, push, stall, rxv, rxr, txv, txr, got;
    logic [7:0] adr, rxd, push_byte;
    logic [3:0] sel;
    logic [31:0] dw, dr;
    sdp_tx_type frm, got_frm;
    int n_fail, compares;
    logic [7:0] sent[$];
    sdp_tx_type rcv[$];
    sdp_packer #(.MS_CYCLES(4)) DUT (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
        .rx_valid(rxv), .rx_data(rxd), .rx_ready(rxr), .tx_valid(txv), .tx_frm(frm), .tx_ready(txr));
    sdp_far_end far (.mclk(mclk), .rst_n(rst_n), .push(push), .push_byte(push_byte), .stall(stall),
        .rx_valid(rxv), .rx_data(rxd), .rx_ready(rxr), .tx_valid(txv), .tx_frm(frm), .tx_ready(txr),
        .got(got), .got_frm(got_frm));
    // clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // collect accepted network bytes
    always @(posedge mclk) begin
        if (got === 1'b1) begin
            rcv.push_back(got_frm);
        end
    end
    task summarize;
        $display("mismatches %0d, compares %0d", n_fail, compares);
        if (n_fail == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    task fault(input string m);
        $display("wrong value at %0t: %s", $time, m);
        n_fail++;
    endtask : fault
    task cmp_word(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            fault($sformatf("word %h, expected %h", g, e));
        end
    endtask : cmp_word
    task cmp_out(input sdp_tx_type g, input sdp_tx_type e);
        compares++;
        if (g !== e) begin
            fault($sformatf("tx %h, expected %h", g, e));
        end
    endtask : cmp_out
    // one classic bus cycle, held until ack is sampled
    task wb_req(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int t;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dw <= d;
        t = 0;
        do begin
            @(posedge mclk);
            t++;
        end while (ack !== 1'b1 && t < 50);
        r = dr;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (t >= 50) begin
            fault("no ack");
            summarize();
        end
        @(posedge mclk);
    endtask : wb_req
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb_req(1'b1, a, d, r);
    endtask : wr
    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        wb_req(1'b0, a, 32'h0, r);
        cmp_word(r, e);
    endtask : rd_chk
    function automatic logic [31:0] dlm(logic [7:0] d1, logic [7:0] d2, logic m2, logic [1:0] p);
        return {13'h0, p, m2, d2, d1};
    endfunction : dlm
    task cfg(input logic [31:0] len, input logic [31:0] dl, input logic [31:0] frc);
        wr(8'h00, len);
        wr(8'h04, dl);
        wr(8'h08, frc);
    endtask : cfg
    task send(input logic [7:0] b[$]);
        foreach (b[i]) begin
            push <= 1'b1;
            push_byte <= b[i];
            sent.push_back(b[i]);
            @(posedge mclk);
        end
        push <= 1'b0;
        @(posedge mclk);
    endtask : send
    // wait for n bytes, compare them against the logged serial bytes
    task chk_frame(input int base, input int n, input logic [31:0] dest, input logic bc);
        int w;
        w = 0;
        while (rcv.size() < n && w < 8000) begin
            @(posedge mclk);
            w++;
        end
        if (rcv.size() < n) begin
            fault("frame missing");
            summarize();
        end
        for (int k = 0; k < n; k++) begin
            cmp_out(rcv.pop_front(), {sent[base+k], k == n - 1, bc, dest});
        end
    endtask : chk_frame
    task quiet(input int c);
        repeat (c) @(posedge mclk);
        cmp_word(rcv.size(), 0);
    endtask : quiet
    initial begin
        int b;
        logic [7:0] big[$];
        n_fail = 0;
        compares = 0;
        {rst_n, cyc, stb, we, push, stall} = '0;
        {adr, dw, push_byte} = '0;
        sel = 4'hf;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        // register defaults, narrow field, unmapped and read-only places
        rd_chk(8'h00, 32'h0);
        rd_chk(8'h04, 32'h0001_0000);
        rd_chk(8'h08, 32'h0);
        wr(8'h40, 32'hffff_ffff);
        rd_chk(8'h40, 32'h0);
        wr(8'h00, 32'hffff_ffff);
        rd_chk(8'h00, 32'h0000_07ff);
        wr(8'h14, 32'hffff_ffff);
        rd_chk(8'h14, 32'h0);
        // single byte lane write leaves the other lanes alone
        sel <= 4'h2;
        wr(8'h04, 32'hffff_3bff);
        sel <= 4'hf;
        rd_chk(8'h04, 32'h0001_3b00);
        cfg(0, dlm(8'h00, 8'h00, 1'b1, 2'd0), 0);
        b = sent.size();
        send({8'h11, 8'h22, 8'h33});
        for (int k = 0; k < 3; k++) chk_frame(b + k, 1, 0, 0); // own frame
        // length limit, rest flushed by idle timer, sink stalling
        stall <= 1'b1;
        cfg(3, dlm(8'hfe, 8'h00, 1'b0, 2'd0), 1);
        b = sent.size();
        send({8'h01, 8'h02, 8'h03, 8'h04, 8'h05});
        chk_frame(b, 3, 0, 0); // length close
        chk_frame(b + 3, 2, 0, 0); // idle flush
        stall <= 1'b0;
        cfg(0, dlm(8'h0d, 8'h0a, 1'b1, 2'd0), 0);
        b = sent.size();
        send({8'h41, 8'h0a, 8'h0d});
        quiet(100); // no close yet
        send({8'h0a});
        chk_frame(b, 4, 0, 0); // pair close
        wr(8'h04, dlm(8'h0d, 8'h0a, 1'b0, 2'd0));
        b = sent.size();
        send({8'h41, 8'h0a});
        chk_frame(b, 2, 0, 0); // second alone
        send({8'h0d});
        chk_frame(b + 2, 1, 0, 0); // first alone
        for (int p = 0; p < 3; p++) begin
            wr(8'h04, dlm(8'h0d, 8'h0a, 1'b1, p[1:0]));
            b = sent.size();
            send({8'h41, 8'h0d, 8'h0a});
            if (p > 0) quiet(40); // tail awaited
            for (int j = 0; j < p; j++) send({8'h55 + j[7:0]});
            chk_frame(b, 3 + p, 0, 0); // tail bytes
        end
        wr(8'h04, dlm(8'h00, 8'h0a, 1'b1, 2'd1));
        b = sent.size();
        send({8'h41, 8'h0a});
        chk_frame(b, 2, 0, 0); // tail ignored
        wr(8'h04, dlm(8'hfe, 8'h00, 1'b0, 2'd0));
        for (int k = 0; k < 1024; k++) big.push_back(8'h01 + k[7:0] % 8'h40);
        b = sent.size();
        send(big);
        chk_frame(b, 1024, 0, 0); // full buffer
        // destination range at and past its largest span, then broadcast
        cfg(0, dlm(8'h00, 8'h00, 1'b1, 2'd0), 0);
        for (int e = 8'h40; e < 8'h42; e++) begin
            wr(8'h0c, 32'h0a00_0001);
            wr(8'h10, 32'h0a00_0000 | e);
            b = sent.size();
            send({8'h77});
            for (int k = 0; k < (e == 8'h40 ? 64 : 1); k++) chk_frame(b, 1, 32'h0a00_0001 + k, 0); // each dest
        end
        wr(8'h0c, 32'h0a00_00ff);
        wr(8'h10, 32'h0);
        b = sent.size();
        send({8'h78});
        chk_frame(b, 1, 32'h0a00_00ff, 1); // subnet broadcast
        quiet(50);
        // sixteen flushes so far, idle and empty
        rd_chk(8'h14, 32'h0010_0000);
        summarize();
    end
endmodule : sdp_packer_test
`default_nettype wire
